// ===== design/radio_cfg_pkg.sv
// Purpose: Constants and types for the radio state control configuration block
// Assumes: Byte-wide register port, 50 MHz system clock
// Notes: Field layouts mirror the two configuration registers bit for bit
// Overview of operation
// - Clear-channel policy: 0 always, 1 low signal, 2 not receiving, 3 both; reset 3
// - Clear-channel output follows the policy currently selected
// - After reception go to idle, synth-on, transmit or stay receiving; reset idle
// - After transmission go to idle, synth-on, stay transmitting or receive; reset idle
// - Auto-calibration: never, leaving idle, or on automatic return to idle
// - Policy 3 calibrates on every fourth automatic return to idle, counted modulo four
// - Pin-control enable at bit 1 lets external pins steer state changes; resets clear
// - Oscillator-force bit 0 keeps crystal oscillator running in sleep; resets clear
package radio_cfg_pkg;
   localparam logic [5:0] ADDR_EXIT_POLICY = 6'h17;
   localparam logic [5:0] ADDR_CAL_POWER = 6'h18;
   localparam logic [1:0] CLEAR_POLICY_RESET = 2'h3;
   localparam logic [1:0] EXIT_RESET = 2'h0;
   localparam logic [1:0] CAL_RESET = 2'h0;
   localparam logic [1:0] POWER_ON_TIMEOUT_RESET = 2'h1;
   localparam logic [1:0] RETURN_WRAP = 2'h3;

   typedef enum logic [1:0] {
      CLEAR_ALWAYS = 2'h0,
      CLEAR_LOW_SIGNAL = 2'h1,
      CLEAR_NOT_RECEIVING = 2'h2,
      CLEAR_BOTH = 2'h3
   } clear_policy_t;

   typedef enum logic [1:0] {
      CAL_NEVER = 2'h0,
      CAL_FROM_IDLE = 2'h1,
      CAL_TO_IDLE = 2'h2,
      CAL_EVERY_FOURTH = 2'h3
   } cal_policy_t;

   // Radio states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SYNTH_ON = 5'h02,
      ST_RECEIVE = 5'h04,
      ST_TRANSMIT = 5'h08,
      ST_SLEEP = 5'h10
   } radio_state_t;

   typedef struct packed {
      logic [1:0] clear_channel_policy;
      logic [1:0] receive_exit_state;
      logic [1:0] transmit_exit_state;
   } exit_policy_t;

   typedef struct packed {
      logic [1:0] auto_calibration_policy;
      logic [1:0] power_on_timeout;
      logic pin_control_enable;
      logic oscillator_force_bit;
   } cal_power_t;

   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Radio events toward the state machine
   typedef struct packed {
      logic start_rx;
      logic start_tx;
      logic start_synth;
      logic go_idle;
      logic go_sleep;
      logic rx_done;
      logic tx_done;
      logic pin_rx;
      logic pin_tx;
      logic pin_idle;
   } radio_evt_t;
endpackage

// ===== design/exit_state_select.sv
// Purpose: Maps an exit field to the next radio state
// Assumes: Two-bit field codes as in the configuration register
// Notes: Pure combinational leaf
`timescale 1ns/1ps
module exit_state_select
   import radio_cfg_pkg::*;
(
   input wire logic is_rx,
   input wire logic [1:0] field,
   output radio_state_t next_state
);
   // Receive and transmit exits map every code the same way
   always_comb
   begin
      case (field)
         2'h0: next_state = ST_IDLE;
         2'h1: next_state = ST_SYNTH_ON;
         2'h2: next_state = is_rx ? ST_TRANSMIT : ST_TRANSMIT;
         2'h3: next_state = is_rx ? ST_RECEIVE : ST_RECEIVE;
         default: next_state = ST_IDLE;
      endcase
   end
endmodule

// ===== design/radio_state_control_config.sv
// Purpose: Two configuration registers and the radio state logic they steer
// Assumes: Register port synchronous to clk_sys; one access per cycle
// Notes: Read data is registered and appears the cycle after rd
`timescale 1ns/1ps
module radio_state_control_config
   import radio_cfg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input radio_cfg_pkg::reg_req_t req,
   input radio_cfg_pkg::radio_evt_t evt,
   input wire logic rssi_below_threshold,
   input wire logic packet_receiving,
   output logic [7:0] rdata_q,
   output logic clear_channel_output_q,
   output logic [4:0] radio_state_q,
   output logic calibrate_q,
   output logic crystal_oscillator_on_q,
   output logic preamble_start_q
);
   import radio_cfg_pkg::*;

   exit_policy_t exit_q;
   cal_power_t calp_q;
   radio_state_t state_q;
   radio_state_t state_d;
   radio_state_t rx_exit;
   radio_state_t tx_exit;
   logic [1:0] return_count_q;
   logic auto_return;
   logic idle_cmd;
   logic leave_idle;
   logic cal_d;

   function automatic logic clear_of(input logic [1:0] pol, input logic low, input logic rcv);
      case (pol)
         CLEAR_ALWAYS: clear_of = 1'b1;
         CLEAR_LOW_SIGNAL: clear_of = low;
         CLEAR_NOT_RECEIVING: clear_of = !rcv;
         default: clear_of = low && !rcv;
      endcase
   endfunction

   exit_state_select u_rx_exit (
      .is_rx(1'b1),
      .field(exit_q.receive_exit_state),
      .next_state(rx_exit)
   );

   exit_state_select u_tx_exit (
      .is_rx(1'b0),
      .field(exit_q.transmit_exit_state),
      .next_state(tx_exit)
   );

   // Register writes; upper two bits never stored so they read zero
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         exit_q <= '{CLEAR_POLICY_RESET, EXIT_RESET, EXIT_RESET};
         calp_q <= '{CAL_RESET, POWER_ON_TIMEOUT_RESET, 1'b0, 1'b0};
      end
      else if (req.wr)
      begin
         if (req.addr == ADDR_EXIT_POLICY)
            exit_q <= req.wdata[5:0];
         if (req.addr == ADDR_CAL_POWER)
            calp_q <= req.wdata[5:0];
      end
   end

   // Registered read; unmapped addresses read zero
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         rdata_q <= 8'h00;
      else if (req.rd)
      begin
         if (req.addr == ADDR_EXIT_POLICY)
            rdata_q <= {2'h0, exit_q};
         else if (req.addr == ADDR_CAL_POWER)
            rdata_q <= {2'h0, calp_q};
         else
            rdata_q <= 8'h00;
      end
   end

   // Next radio state; an enabled pin ranks with its software command except pin_rx in synth-on, disabled pins do nothing
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (evt.start_rx || (calp_q.pin_control_enable && evt.pin_rx))
               state_d = ST_RECEIVE;
            else if (evt.start_tx || (calp_q.pin_control_enable && evt.pin_tx))
               state_d = ST_TRANSMIT;
            else if (evt.start_synth)
               state_d = ST_SYNTH_ON;
            else if (evt.go_sleep)
               state_d = ST_SLEEP;
         end
         ST_SYNTH_ON:
         begin
            if (evt.go_idle || (calp_q.pin_control_enable && evt.pin_idle))
               state_d = ST_IDLE;
            else if (evt.start_tx || (calp_q.pin_control_enable && evt.pin_tx))
               state_d = ST_TRANSMIT;
            else if (evt.start_rx)
               state_d = ST_RECEIVE;
         end
         ST_RECEIVE:
         begin
            if (evt.go_idle || (calp_q.pin_control_enable && evt.pin_idle))
               state_d = ST_IDLE;
            else if (evt.rx_done)
               state_d = rx_exit;
         end
         ST_TRANSMIT:
         begin
            if (evt.go_idle || (calp_q.pin_control_enable && evt.pin_idle))
               state_d = ST_IDLE;
            else if (evt.tx_done)
               state_d = tx_exit;
         end
         ST_SLEEP:
         begin
            if (evt.go_idle || (calp_q.pin_control_enable && evt.pin_idle))
               state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // An idle command, by software or by an enabled pin, beats any done event
   assign idle_cmd = evt.go_idle || (calp_q.pin_control_enable && evt.pin_idle);
   // Automatic return is a done event leading to idle, not a command
   assign auto_return = ((state_q == ST_RECEIVE) && evt.rx_done && !idle_cmd &&
                         (rx_exit == ST_IDLE)) ||
                        ((state_q == ST_TRANSMIT) && evt.tx_done && !idle_cmd &&
                         (tx_exit == ST_IDLE));
   assign leave_idle = (state_q == ST_IDLE) &&
                       (state_d == ST_RECEIVE || state_d == ST_TRANSMIT ||
                        state_d == ST_SYNTH_ON);

   // Calibration decision
   always_comb
   begin
      case (calp_q.auto_calibration_policy)
         CAL_NEVER: cal_d = 1'b0;
         CAL_FROM_IDLE: cal_d = leave_idle;
         CAL_TO_IDLE: cal_d = auto_return;
         default: cal_d = auto_return && (return_count_q == RETURN_WRAP);
      endcase
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // Modulo-four count of automatic returns to idle
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         return_count_q <= 2'h0;
      else if (auto_return)
         return_count_q <= return_count_q + 2'h1;
   end

   // Registered outputs
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         clear_channel_output_q <= 1'b0;
         radio_state_q <= ST_IDLE;
         calibrate_q <= 1'b0;
         crystal_oscillator_on_q <= 1'b1;
         preamble_start_q <= 1'b0;
      end
      else
      begin
         clear_channel_output_q <= clear_of(exit_q.clear_channel_policy,
                                            rssi_below_threshold, packet_receiving);
         radio_state_q <= state_d;
         calibrate_q <= cal_d;
         // Oscillator stops in sleep unless forced on
         crystal_oscillator_on_q <= (state_d != ST_SLEEP) || calp_q.oscillator_force_bit;
         preamble_start_q <= (state_q == ST_TRANSMIT) && evt.tx_done && !idle_cmd &&
                             (tx_exit == ST_TRANSMIT);
      end
   end

   a_clear_always: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (exit_q.clear_channel_policy == CLEAR_ALWAYS) |=> clear_channel_output_q)
      else $error("clear channel low under always-clear policy");
   a_clear_both: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (exit_q.clear_channel_policy == CLEAR_BOTH) && packet_receiving |=> !clear_channel_output_q)
      else $error("clear channel high while receiving");
   a_rx_exit_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state_q == ST_RECEIVE) && evt.rx_done && exit_q.receive_exit_state == 2'h0
      |=> state_q == ST_IDLE)
      else $error("receive exit to idle missed");
   a_tx_exit_rx: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state_q == ST_TRANSMIT) && evt.tx_done && !idle_cmd &&
      exit_q.transmit_exit_state == 2'h3 |=> state_q == ST_RECEIVE)
      else $error("transmit exit to receive missed");
   a_cal_never: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $past(calp_q.auto_calibration_policy) == CAL_NEVER |-> !calibrate_q)
      else $error("calibration under never policy");
   a_cal_idle_leave: assert property (@(posedge clk_sys) disable iff (!reset_n)
      calp_q.auto_calibration_policy == CAL_FROM_IDLE && state_q == ST_IDLE &&
      state_d == ST_RECEIVE |=> calibrate_q)
      else $error("no calibration on leaving idle");
   a_cal_fourth: assert property (@(posedge clk_sys) disable iff (!reset_n)
      calibrate_q && $past(calp_q.auto_calibration_policy) == CAL_EVERY_FOURTH
      |-> return_count_q == 2'h0)
      else $error("calibration not on fourth return");
   a_sleep_osc: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_q == ST_SLEEP && !$past(calp_q.oscillator_force_bit) |-> !crystal_oscillator_on_q)
      else $error("oscillator running in sleep without force");
   a_pins_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_q == ST_IDLE && !calp_q.pin_control_enable && !evt.start_rx && !evt.start_tx &&
      !evt.start_synth && !evt.go_sleep |=> state_q == ST_IDLE)
      else $error("pins moved state while disabled");
   a_upper_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $past(req.rd) |-> rdata_q[7:6] == 2'h0)
      else $error("unused bits read nonzero");
endmodule

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the radio state control configuration block
// Assumes: Inputs change 1 ns after the rising edge and outputs are checked there too
// Notes: Counts automatic returns itself, so every-fourth calibration is predictable
`timescale 1ns/1ps
module tb;
   import radio_cfg_pkg::*;
   localparam logic [9:0] E_RX = 10'h200, E_TX = 10'h100, E_SYN = 10'h080, E_IDLE = 10'h040;
   localparam logic [9:0] E_SLP = 10'h020, E_RXD = 10'h010, E_TXD = 10'h008;
   localparam logic [9:0] E_PRX = 10'h004, E_PTX = 10'h002, E_PIDLE = 10'h001;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   reg_req_t req = '0;
   logic [9:0] ev = 10'h000;
   logic rssi_below_threshold = 1'b0;
   logic packet_receiving = 1'b0;
   logic [7:0] rdata_q;
   logic [4:0] radio_state_q;
   logic clear_channel_output_q, calibrate_q, crystal_oscillator_on_q, preamble_start_q;
   int fail_count = 0;
   int check_count = 0;
   int ret_n = 0;
   int cp = 0;
   // Exit codes map the same way for both directions: idle, synth-on, transmit, receive
   logic [4:0] st_tab [4] = '{5'h01, 5'h02, 5'h08, 5'h04};

   radio_state_control_config dut (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .req(req),
      .evt(radio_evt_t'(ev)),
      .rssi_below_threshold(rssi_below_threshold),
      .packet_receiving(packet_receiving),
      .rdata_q(rdata_q),
      .clear_channel_output_q(clear_channel_output_q),
      .radio_state_q(radio_state_q),
      .calibrate_q(calibrate_q),
      .crystal_oscillator_on_q(crystal_oscillator_on_q),
      .preamble_start_q(preamble_start_q)
   );

   // 50 MHz system clock
   always #10 clk_sys = ~clk_sys;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // Every access ends with an idle edge so no strobe is driven twice in one step
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      req = '{1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      #1 req = '0;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      #1 req = '0;
      chk(rdata_q, exp);
      @(posedge clk_sys);
      #1;
   endtask

   // Pulse events, then check the one-cycle outputs in the cycle they stand
   task automatic pulse(input logic [9:0] m, input logic [4:0] st, input logic cal,
      input logic pre);
      ev = m;
      @(posedge clk_sys);
      #1 ev = 10'h000;
      chk({3'h0, radio_state_q}, {3'h0, st});
      chk({7'h00, calibrate_q}, {7'h00, cal});
      chk({7'h00, preamble_start_q}, {7'h00, pre});
      @(posedge clk_sys);
      #1;
   endtask

   // Expected calibration on an automatic return; the count runs whatever the policy
   function automatic logic ret_cal();
      ret_n++;
      return (cp == 2) || (cp == 3 && (ret_n - 1) % 4 == 3);
   endfunction

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Cuts a hang short, far beyond the expected run of under a thousand cycles
   initial
   begin
      #(20 * 20000);
      fail_count++;
      stop_test();
   end

   initial
   begin
      repeat (3) @(posedge clk_sys);
      #1;
      chk({3'h0, radio_state_q}, 8'h01);
      chk({7'h00, crystal_oscillator_on_q}, 8'h01);
      reset_n = 1'b1;
      rd(ADDR_EXIT_POLICY, 8'h30);
      rd(ADDR_CAL_POWER, 8'h04);
      wr(ADDR_EXIT_POLICY, 8'hff);
      rd(ADDR_EXIT_POLICY, 8'h3f);
      wr(ADDR_CAL_POWER, 8'hc8);
      rd(ADDR_CAL_POWER, 8'h08);
      wr(6'h20, 8'h55);
      rd(6'h20, 8'h00);
      rd(ADDR_EXIT_POLICY, 8'h3f);
      wr(ADDR_CAL_POWER, 8'h00);
      // Every policy against every input combination
      for (int p = 0; p < 4; p++)
      begin
         wr(ADDR_EXIT_POLICY, 8'(p << 4));
         for (int k = 0; k < 4; k++)
         begin
            rssi_below_threshold = k[0];
            packet_receiving = k[1];
            @(posedge clk_sys);
            #1;
            chk({7'h00, clear_channel_output_q},
               {7'h00, (p[0] ? k[0] : 1'b1) & (p[1] ? ~k[1] : 1'b1)});
         end
      end
      // Exit states after reception and transmission
      for (int c = 0; c < 4; c++)
      begin
         wr(ADDR_EXIT_POLICY, 8'(c << 2));
         pulse(E_RX, 5'h04, 1'b0, 1'b0);
         pulse(E_RXD, st_tab[c], c == 0 ? ret_cal() : 1'b0, 1'b0);
         if (c != 0)
            pulse(E_IDLE, 5'h01, 1'b0, 1'b0);
         wr(ADDR_EXIT_POLICY, 8'(c));
         pulse(E_TX, 5'h08, 1'b0, 1'b0);
         pulse(E_TXD, st_tab[c], c == 0 ? ret_cal() : 1'b0, c == 2);
         if (c != 0)
            pulse(E_IDLE, 5'h01, 1'b0, 1'b0);
      end
      // Calibration policies; five returns each so the fourth-return case is hit
      wr(ADDR_EXIT_POLICY, 8'h00);
      for (int p = 0; p < 4; p++)
      begin
         cp = p;
         wr(ADDR_CAL_POWER, 8'(p << 4));
         pulse(E_SYN, 5'h02, p == 1, 1'b0);
         pulse(E_IDLE, 5'h01, 1'b0, 1'b0);
         for (int i = 0; i < 5; i++)
         begin
            pulse(i[0] ? E_TX : E_RX, i[0] ? 5'h08 : 5'h04, p == 1, 1'b0);
            pulse(i[0] ? E_TXD : E_RXD, 5'h01, ret_cal(), 1'b0);
         end
      end
      cp = 0;
      wr(ADDR_CAL_POWER, 8'h00);
      pulse(E_PRX, 5'h01, 1'b0, 1'b0);
      wr(ADDR_CAL_POWER, 8'h02);
      pulse(E_PRX, 5'h04, 1'b0, 1'b0);
      pulse(E_PIDLE, 5'h01, 1'b0, 1'b0);
      pulse(E_PTX, 5'h08, 1'b0, 1'b0);
      pulse(E_PIDLE, 5'h01, 1'b0, 1'b0);
      for (int f = 0; f < 2; f++)
      begin
         wr(ADDR_CAL_POWER, 8'(f));
         pulse(E_SLP, 5'h10, 1'b0, 1'b0);
         chk({7'h00, crystal_oscillator_on_q}, 8'(f));
         pulse(E_IDLE, 5'h01, 1'b0, 1'b0);
         chk({7'h00, crystal_oscillator_on_q}, 8'h01);
      end
      stop_test();
   end
endmodule
